/* core/rbh_pkg.sv */
// Purpose: shared constants for the reclose blocking, health and interface block
// Assumes: one 25 MHz clock, millisecond time base derived inside the core
// Notes:   action and health codes are fixed integer encodings seen at the ports
package rbh_pkg;
  // geometry
  localparam int NUM_CH    = 5;
  localparam int NUM_CYC   = 5;
  localparam int PICK_SRC  = 6;
  localparam int EARLY_CYC = 2;   // cycles that support early start
  localparam int TIME_W    = 16;
  localparam int CNT_W     = 16;
  localparam int NUM_CNT   = 7;

  // per channel, per cycle action codes
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_BLOCK  = 2'h1;
  localparam logic [1:0] ACT_START  = 2'h2;
  localparam logic [1:0] ACT_EARLY  = 2'h3;

  // health encoding
  localparam logic [1:0] HEALTH_NORMAL  = 2'h1;
  localparam logic [1:0] HEALTH_WARNING = 2'h2;
  localparam logic [1:0] HEALTH_ALARM   = 2'h3;

  // counter word indices
  localparam logic [2:0] CNT_GOOD = 3'h0;
  localparam logic [2:0] CNT_FAIL = 3'h1;
  localparam logic [2:0] CNT_CYC1 = 3'h2;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  // positions inside the synchroniser vector
  localparam int SYN_BLOCK  = 30;
  localparam int SYN_POS    = 31;
  localparam int SYN_TRIP   = 32;
  localparam int SYN_READY  = 33;
  localparam int SYN_SYNC   = 34;
  localparam int SYN_MASTER = 35;
  localparam int SYN_W      = 36;

  // millisecond time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 15;
endpackage

/* core/rbh_count_store.sv */
// Purpose: sequence counters with load and increment, registered read port
// Assumes: retention across power loss is done by the host reloading words
// Notes:   an increment in the same cycle as a load adds to the loaded value
`timescale 1ns/1ps
module rbh_count_store #(
  parameter int N = 7,
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // increment requests, one bit per word
  input  wire logic [N-1:0]         incMask,
  // load command
  input  wire logic                 loadEn,
  input  wire logic [2:0]           loadSel,
  input  wire logic [W-1:0]         loadValue,
  // read port
  input  wire logic [2:0]           readSel,
  output logic      [W-1:0]         readData
);
  typedef struct packed {
    logic [N-1:0][W-1:0] word;
    logic [W-1:0]        rd;
  } rbh_store_t;

  rbh_store_t r;
  rbh_store_t next_r;

  // load first, then increment, so a counted event is never lost
  always_comb begin
    next_r = r;
    for (int i = 0; i < N; i++) begin
      if (loadEn && (loadSel == 3'(i))) begin
        next_r.word[i] = loadValue;  // [RULE13]
      end
      if (incMask[i]) begin
        next_r.word[i] = next_r.word[i] + 1'b1;
      end
    end
    next_r.rd = (int'(readSel) < N) ? r.word[readSel] : '0;
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign readData = r.rd;
endmodule // rbh_count_store

/* core/rbh_core.sv */
// Purpose: blocking, configuration health and breaker interface of a reclosing controller
// Assumes: dead and reclaim timing done outside, reported by deadTimeDone and reclaimTimeDone
// Notes:   connection bits are static straps, caught on the first edge after reset release
`timescale 1ns/1ps
// Contract
// (RULE1) block input from any condition shows on the blocked output.
// (RULE2) breaker position unconnected: no reclosing at all, health at alarm.
// (RULE3) master hold connected and max cycles above one: warning, one cycle only.
// (RULE4) master hold connected with downstream skip on: warning, skip disabled.
// (RULE5) start action with pickup or trip unconnected: warning, channel never starts.
// (RULE6) early start delay not below window: warning, no window check for that start.
// (RULE7) block action with pickup unconnected: warning, block never takes effect.
// (RULE8) early start on cycles three to five behaves as start, with warning.
// (RULE9) breaker ready unconnected while checking on: warning, checking turned off.
// (RULE10) no alarm or warning condition: health normal, full operation.
// (RULE11) five channel pickups, each an OR of six sources.
// (RULE12) five cycle active flags, one per cycle number while it runs.
// (RULE13) good, failed and per cycle counters keep values and accept loads.
// (RULE14) breaker side drives ready when it can do an open close cycle.
// (RULE15) close command withheld while master hold is active.
// (RULE16) master keeps hold active through sequences, block and lockout.
// (RULE17) health codes normal, warning, alarm; alarm wins over warning.
// (RULE18) connections sampled at reset; health recomputed on every setting change.
module rbh_core #(
  parameter int TICK_CYCLES = rbh_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // connection straps
  input  wire logic                   connBreakerPos,
  input  wire logic                   connMasterHold,
  input  wire logic                   connBreakerReady,
  input  wire logic                   connProtectionTrip,
  input  wire logic [4:0]             connChannelPickup,
  // settings
  input  wire logic [2:0]             maxCycleCount,
  input  wire logic                   downstreamSkipEnable,
  input  wire logic                   breakerReadyCheck,
  input  wire logic [49:0]            channelCycleAction,
  input  wire logic [159:0]           earlyStartDelay,
  input  wire logic [15:0]            actionWindowTime,
  // field pins
  input  wire logic                   blockIn,
  input  wire logic                   breakerPosIn,
  input  wire logic [29:0]            channelPickupIn,
  input  wire logic                   protectionTripIn,
  input  wire logic                   breakerReadyIn,
  input  wire logic                   synchroReleaseIn,
  input  wire logic                   masterHold,
  // sequence timing from outside
  input  wire logic                   deadTimeDone,
  input  wire logic                   reclaimTimeDone,
  // counter commands
  input  wire logic                   cntLoadEn,
  input  wire logic [2:0]             cntLoadSel,
  input  wire logic [15:0]            cntLoadValue,
  input  wire logic [2:0]             cntReadSel,
  // status
  output logic      [1:0]             health,
  output logic                        blocked,
  output logic      [4:0]             cycleActiveFlag,
  output logic                        downstreamSkipActive,
  output logic                        breakerReadyCheckActive,
  output logic                        sequenceGood,
  output logic                        sequenceFailed,
  output logic      [15:0]            cntReadData,
  // breaker commands
  output logic                        breakerOpenCmd,
  output logic                        breakerCloseCmd
);
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_OPEN    = 5'h02,
    ST_DEAD    = 5'h04,
    ST_CLOSE   = 5'h08,
    ST_RECLAIM = 5'h10
  } rbh_state_t;

  typedef struct packed {
    rbh_state_t                 st;
    logic [2:0]                 cyc;
    logic [2:0]                 doneCyc;
    logic                       capt;
    logic                       connPos;
    logic                       connMaster;
    logic                       connReady;
    logic                       connTrip;
    logic [4:0]                 connPick;
    logic [rbh_pkg::SYN_W-1:0]  s1;
    logic [rbh_pkg::SYN_W-1:0]  s2;
    logic [rbh_pkg::TICK_W-1:0] tickCnt;
    logic [15:0]                actTimer;
    logic [1:0]                 health;
    logic                       blocked;
    logic [4:0]                 cycFlags;
    logic                       openCmd;
    logic                       closeCmd;
    logic                       good;
    logic                       fail;
    logic                       skipOn;
    logic                       readyOn;
  } rbh_core_state_t;

  rbh_core_state_t r;
  rbh_core_state_t next_r;

  // action code of one channel in one cycle
  function automatic logic [1:0] actionOf(input logic [49:0] acts, input int ch, input int cy);
    actionOf = acts[(ch * rbh_pkg::NUM_CYC + cy) * 2 +: 2];
  endfunction

  // early start delay of one channel in one early cycle
  function automatic logic [15:0] delayOf(input logic [159:0] dl, input int ch, input int cy);
    delayOf = dl[(ch * rbh_pkg::EARLY_CYC + cy) * 16 +: 16];
  endfunction

  // next state
  always_comb begin
    logic       warn;
    logic [1:0] act;
    logic [2:0] effMax;
    logic       pk;
    logic       chanOk;
    logic       startReq;
    logic       blockAct;
    logic       readyOk;
    logic       closePermit;
    logic       closedNow;
    logic       tripNow;
    logic       anyPick;
    logic       allowed;
    logic       toFail;
    warn        = 1'b0;
    act         = rbh_pkg::ACT_IGNORE;
    effMax      = 3'h0;
    pk          = 1'b0;
    chanOk      = 1'b0;
    startReq    = 1'b0;
    blockAct    = 1'b0;
    readyOk     = 1'b0;
    closePermit = 1'b0;
    closedNow   = 1'b0;
    tripNow     = 1'b0;
    anyPick     = 1'b0;
    allowed     = 1'b0;
    toFail      = 1'b0;
    next_r      = r;
    next_r.good = 1'b0;
    next_r.fail = 1'b0;

    // two stage synchronisers, only s2 is read below
    next_r.s1 = {masterHold, synchroReleaseIn, breakerReadyIn, protectionTripIn,
                 breakerPosIn, blockIn, channelPickupIn};
    next_r.s2 = r.s1;
    closedNow = r.s2[rbh_pkg::SYN_POS];
    tripNow   = r.s2[rbh_pkg::SYN_TRIP];
    anyPick   = |r.s2[29:0];

    // straps caught once, on the first edge after reset release
    if (!r.capt) begin
      next_r.capt       = 1'b1;  // [RULE18]
      next_r.connPos    = connBreakerPos;
      next_r.connMaster = connMasterHold;
      next_r.connReady  = connBreakerReady;
      next_r.connTrip   = connProtectionTrip;
      next_r.connPick   = connChannelPickup;
    end

    // health re-evaluated every cycle from live settings
    if (r.connMaster && (maxCycleCount > 3'h1)) warn = 1'b1;  // [RULE3]
    if (r.connMaster && downstreamSkipEnable) warn = 1'b1;     // [RULE4]
    for (int ch = 0; ch < rbh_pkg::NUM_CH; ch++) begin
      for (int cy = 0; cy < rbh_pkg::NUM_CYC; cy++) begin
        act = actionOf(channelCycleAction, ch, cy);
        if (((act == rbh_pkg::ACT_START) || (act == rbh_pkg::ACT_EARLY)) &&
            (!r.connPick[ch] || !r.connTrip)) warn = 1'b1;  // [RULE5]
        if ((act == rbh_pkg::ACT_BLOCK) && !r.connPick[ch]) warn = 1'b1;  // [RULE7]
        if (act == rbh_pkg::ACT_EARLY) begin
          if (cy >= rbh_pkg::EARLY_CYC) begin
            warn = 1'b1;  // [RULE8]
          end else if (delayOf(earlyStartDelay, ch, cy) >= actionWindowTime) begin
            warn = 1'b1;  // [RULE6]
          end
        end
      end
    end
    if (!r.connReady && breakerReadyCheck) warn = 1'b1;  // [RULE9]
    // alarm outranks warning; neither means normal
    if (!r.connPos) begin
      next_r.health = rbh_pkg::HEALTH_ALARM;  // [RULE2] [RULE17]
    end else if (warn) begin
      next_r.health = rbh_pkg::HEALTH_WARNING;  // [RULE17]
    end else begin
      next_r.health = rbh_pkg::HEALTH_NORMAL;  // [RULE10]
    end
    next_r.skipOn  = downstreamSkipEnable && !r.connMaster;  // [RULE4]
    next_r.readyOn = breakerReadyCheck && r.connReady;       // [RULE9]
    effMax         = r.connMaster ? 3'h1 : maxCycleCount;     // [RULE3]

    // millisecond time base and action window timer
    next_r.tickCnt = (int'(r.tickCnt) >= TICK_CYCLES - 1) ? '0 : r.tickCnt + 1'b1;
    if ((r.st == ST_IDLE) || (r.st == ST_RECLAIM)) begin
      if (!anyPick) begin
        next_r.actTimer = '0;
      end else if ((r.tickCnt == '0) && (r.actTimer != 16'hffff)) begin
        next_r.actTimer = r.actTimer + 1'b1;
      end
    end else begin
      next_r.actTimer = '0;
    end

    // channel evaluation for the cycle that would start next
    if (r.cyc < 3'(rbh_pkg::NUM_CYC)) begin
      for (int ch = 0; ch < rbh_pkg::NUM_CH; ch++) begin
        act = actionOf(channelCycleAction, ch, int'(r.cyc));
        if ((act == rbh_pkg::ACT_EARLY) && (int'(r.cyc) >= rbh_pkg::EARLY_CYC)) begin
          act = rbh_pkg::ACT_START;  // [RULE8]
        end
        pk     = |r.s2[ch * rbh_pkg::PICK_SRC +: rbh_pkg::PICK_SRC];  // [RULE11]
        chanOk = r.connPick[ch] && r.connTrip;  // [RULE5]
        if ((act == rbh_pkg::ACT_BLOCK) && r.connPick[ch] && pk) begin
          blockAct = 1'b1;  // [RULE7]
        end
        if ((act == rbh_pkg::ACT_START) && chanOk && pk && tripNow &&
            (r.actTimer < actionWindowTime)) begin
          startReq = 1'b1;
        end
        if ((act == rbh_pkg::ACT_EARLY) && chanOk && pk &&
            (r.actTimer >= delayOf(earlyStartDelay, ch, int'(r.cyc))) &&
            ((delayOf(earlyStartDelay, ch, int'(r.cyc)) >= actionWindowTime) ||
             (r.actTimer < actionWindowTime))) begin
          startReq = 1'b1;  // [RULE6]
        end
      end
    end

    // blocking and close permission
    next_r.blocked = r.s2[rbh_pkg::SYN_BLOCK];  // [RULE1]
    allowed        = (r.health != rbh_pkg::HEALTH_ALARM) && !r.blocked && !blockAct;
    readyOk        = !r.readyOn || r.s2[rbh_pkg::SYN_READY];  // [RULE14] [RULE9]
    // master keeps hold up until it can reclose, so one level check suffices
    closePermit    = !r.s2[rbh_pkg::SYN_MASTER] && r.s2[rbh_pkg::SYN_SYNC] && readyOk;  // [RULE15] [RULE16]

    // sequence control
    unique case (r.st)
      ST_IDLE: begin
        if (allowed && startReq && closedNow) begin
          next_r.st  = ST_OPEN;
          next_r.cyc = 3'h1;
        end
      end
      ST_OPEN: begin
        if (!closedNow) next_r.st = ST_DEAD;
      end
      ST_DEAD: begin
        if (r.blocked || blockAct) begin
          toFail = 1'b1;
        end else if (deadTimeDone && closePermit) begin
          next_r.st = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (closedNow) next_r.st = ST_RECLAIM;
      end
      ST_RECLAIM: begin
        if (startReq || !closedNow) begin
          if (allowed && startReq && (r.cyc < effMax)) begin
            next_r.st  = ST_OPEN;
            next_r.cyc = r.cyc + 3'h1;
          end else begin
            toFail = 1'b1;
          end
        end else if (reclaimTimeDone) begin
          next_r.good    = 1'b1;
          next_r.doneCyc = r.cyc;
          next_r.st      = ST_IDLE;
          next_r.cyc     = 3'h0;
        end
      end
    endcase
    if (toFail) begin
      next_r.fail = 1'b1;
      next_r.st   = ST_IDLE;
      next_r.cyc  = 3'h0;
    end
    // alarm health stops every operation at once
    if (r.health == rbh_pkg::HEALTH_ALARM) begin
      next_r.st  = ST_IDLE;  // [RULE2]
      next_r.cyc = 3'h0;
    end

    // registered outputs follow the next state
    next_r.openCmd  = (next_r.st == ST_OPEN);
    next_r.closeCmd = (next_r.st == ST_CLOSE) && closePermit;  // [RULE15]
    next_r.cycFlags = (next_r.st == ST_IDLE) ? 5'h00 :
                      5'(5'h01 << (next_r.cyc - 3'h1));  // [RULE12]
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.health <= rbh_pkg::HEALTH_ALARM;
    end else begin
      r <= next_r;
    end
  end

  // counter increments come from one-cycle sequence pulses
  logic [rbh_pkg::NUM_CNT-1:0] incMask;
  always_comb begin
    incMask = '0;
    incMask[rbh_pkg::CNT_GOOD] = r.good;  // [RULE13]
    incMask[rbh_pkg::CNT_FAIL] = r.fail;
    for (int i = 0; i < rbh_pkg::NUM_CYC; i++) begin
      if (r.good && (r.doneCyc == 3'(i + 1))) incMask[int'(rbh_pkg::CNT_CYC1) + i] = 1'b1;
    end
  end

  rbh_count_store #(
    .N (rbh_pkg::NUM_CNT),
    .W (rbh_pkg::CNT_W)
  ) u_store (
    .clk       (clk),
    .rst_n     (rst_n),
    .incMask   (incMask),
    .loadEn    (cntLoadEn),
    .loadSel   (cntLoadSel),
    .loadValue (cntLoadValue),
    .readSel   (cntReadSel),
    .readData  (cntReadData)
  );

  // outputs straight from the state register
  assign health                  = r.health;
  assign blocked                 = r.blocked;
  assign cycleActiveFlag         = r.cycFlags;
  assign downstreamSkipActive    = r.skipOn;
  assign breakerReadyCheckActive = r.readyOn;
  assign sequenceGood            = r.good;
  assign sequenceFailed          = r.fail;
  assign breakerOpenCmd          = r.openCmd;
  assign breakerCloseCmd         = r.closeCmd;
endmodule // rbh_core

/* testbench/rbh_properties.sv */
// Purpose: port-level checks on the reclose health and breaker block
// Assumes: straps stay put between resets; pins pass a two-stage synchroniser
// Notes:   bound to every rbh_core instance
`timescale 1ns/1ps
module rbh_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // straps and settings
  input wire logic       connBreakerPos,
  input wire logic       connMasterHold,
  input wire logic       connBreakerReady,
  input wire logic       downstreamSkipEnable,
  input wire logic       breakerReadyCheck,
  // pins
  input wire logic       blockIn,
  input wire logic       masterHold,
  // status and commands
  input wire logic [1:0] health,
  input wire logic       blocked,
  input wire logic [4:0] cycleActiveFlag,
  input wire logic       downstreamSkipActive,
  input wire logic       breakerReadyCheckActive,
  input wire logic       sequenceGood,
  input wire logic       breakerOpenCmd,
  input wire logic       breakerCloseCmd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // blocked may lag the pin only by the synchroniser depth plus its output register
  AST_BLOCK_FOLLOW: assert property (blockIn[*4] |=> blocked)
    else $error("blocked did not follow the block pin");
  AST_BLOCK_CAUSE: assert property ($rose(blocked) |-> $past(blockIn, 2) || $past(blockIn, 3)
    || $past(blockIn, 4)) else $error("blocked rose without the block pin");
  // missing position strap: alarm wins and the breaker is never driven
  AST_ALARM: assert property ((!connBreakerPos)[*3] |-> health == rbh_pkg::HEALTH_ALARM
    && !breakerOpenCmd && !breakerCloseCmd) else $error("position strap missing but block not in alarm");
  // four cycles: straps land on the first edge after release, the enables one edge later
  AST_SKIP_EFF: assert property (connBreakerPos && $stable(downstreamSkipEnable) [*4]
    |-> downstreamSkipActive == (downstreamSkipEnable && !connMasterHold)) else $error("skip enable wrong");
  AST_READY_EFF: assert property (connBreakerPos && $stable(breakerReadyCheck) [*4]
    |-> breakerReadyCheckActive == (breakerReadyCheck && connBreakerReady)) else $error("ready check wrong");
  AST_ONE_CYCLE: assert property (connMasterHold[*3] |-> cycleActiveFlag[4:1] == 4'h0)
    else $error("second cycle ran with master hold strapped");
  AST_HOLD_CLOSE: assert property (masterHold[*4] |=> !breakerCloseCmd)
    else $error("close issued under master hold");
  AST_FLAG_ONEHOT: assert property ($onehot0(cycleActiveFlag))
    else $error("more than one cycle flag high");
  AST_OPEN_FLAG: assert property ($rose(breakerOpenCmd) && $past(cycleActiveFlag) == 5'h00
    |-> cycleActiveFlag == 5'h01) else $error("first open without cycle one flag");
  AST_GOOD_PULSE: assert property (sequenceGood |-> cycleActiveFlag == 5'h00 ##1 !sequenceGood)
    else $error("success pulse malformed");
endmodule // rbh_properties

bind rbh_core rbh_properties rbh_properties_inst (.clk, .rst_n, .connBreakerPos, .connMasterHold,
  .connBreakerReady, .downstreamSkipEnable, .breakerReadyCheck, .blockIn, .masterHold, .health, .blocked,
  .cycleActiveFlag, .downstreamSkipActive, .breakerReadyCheckActive, .sequenceGood, .breakerOpenCmd,
  .breakerCloseCmd);

/* testbench/rbh_breaker_model.sv */
// Purpose: behavioural breaker answering open and close commands
// Assumes: position high means closed; closed after reset
// Notes:   opDelay sets stroke length in cycles, 0 answers promptly
`timescale 1ns/1ps
module rbh_breaker_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // commands and stroke length
  input  wire logic       openCmd,
  input  wire logic       closeCmd,
  input  wire logic [3:0] opDelay,
  // breaker pins
  output logic            posClosed,
  output logic            readyOut
);
  logic [3:0] strokeCnt;
  // stored energy always allows a full open-close cycle here
  assign readyOut = 1'b1;
  // a stroke advances only while its command stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      posClosed <= 1'b1;
      strokeCnt <= 4'h0;
    end else if ((openCmd && posClosed) || (closeCmd && !posClosed)) begin
      strokeCnt <= (strokeCnt == opDelay) ? 4'h0 : strokeCnt + 4'h1;
      posClosed <= (strokeCnt == opDelay) ? !posClosed : posClosed;
    end else begin
      strokeCnt <= 4'h0;
    end
  end
endmodule // rbh_breaker_model

/* testbench/rbh_core_bench.sv */
// Purpose: directed test of health, blocking, breaker sequence and counters
// Assumes: tick shortened to 4 clocks, so 1 ms is 4 cycles
// Notes:   straps change only while reset is held
`timescale 1ns/1ps
module rbh_core_bench;
  localparam logic [1:0] NRM = rbh_pkg::HEALTH_NORMAL;
  localparam logic [1:0] WRN = rbh_pkg::HEALTH_WARNING;
  localparam logic [1:0] ALM = rbh_pkg::HEALTH_ALARM;
  // clock, reset and bookkeeping
  logic        clk = 1'b0;
  logic        rstN = 1'b0;
  int          failCount = 0;
  int          nChecks = 0;
  int          cycles = 0;
  // straps {position, master hold, ready, trip} and settings
  logic [3:0]  straps = 4'hf;
  logic [4:0]  connPick = 5'h1f;
  logic [2:0]  maxCyc = 3'h1;
  logic        skipEn = 1'b0, readyChk = 1'b1;
  logic [49:0] action = 50'h2;
  // pins, timing and counter commands
  logic        blockPin = 1'b0, tripPin = 1'b0, syncOk = 1'b1, holdPin = 1'b0;
  logic [29:0] pickPins = 30'h0;
  logic        deadDone = 1'b0, reclaimDone = 1'b0, ldEn = 1'b0;
  logic [2:0]  ldSel = 3'h0, rdSel = 3'h0;
  logic [15:0] ldVal = 16'h0, rdData;
  logic [3:0]  strokeDly = 4'h0;
  // outputs
  logic [1:0]  health;
  logic [4:0]  flags;
  logic        blocked, skipAct, readyAct, good, failed, openCmd, closeCmd, posClosed, readyPin;

  rbh_core #(.TICK_CYCLES(4)) rbh_core_inst (.clk(clk), .rst_n(rstN), .connBreakerPos(straps[3]),
    .connMasterHold(straps[2]), .connBreakerReady(straps[1]), .connProtectionTrip(straps[0]),
    .connChannelPickup(connPick), .maxCycleCount(maxCyc), .downstreamSkipEnable(skipEn),
    .breakerReadyCheck(readyChk), .channelCycleAction(action), .earlyStartDelay(160'h14_0000),
    .actionWindowTime(16'h000a), .blockIn(blockPin), .breakerPosIn(posClosed), .channelPickupIn(pickPins),
    .protectionTripIn(tripPin), .breakerReadyIn(readyPin), .synchroReleaseIn(syncOk), .masterHold(holdPin),
    .deadTimeDone(deadDone), .reclaimTimeDone(reclaimDone), .cntLoadEn(ldEn), .cntLoadSel(ldSel),
    .cntLoadValue(ldVal), .cntReadSel(rdSel), .health(health), .blocked(blocked), .cycleActiveFlag(flags),
    .downstreamSkipActive(skipAct), .breakerReadyCheckActive(readyAct), .sequenceGood(good),
    .sequenceFailed(failed), .cntReadData(rdData), .breakerOpenCmd(openCmd), .breakerCloseCmd(closeCmd));

  rbh_breaker_model rbh_breaker_model_inst (.clk(clk), .rst_n(rstN), .openCmd(openCmd), .closeCmd(closeCmd),
    .opDelay(strokeDly), .posClosed(posClosed), .readyOut(readyPin));

  // 25 MHz clock
  always #20 clk = ~clk;

  // hang guard, far above what the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      endOfTest();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  wire [5:0] watch = {failed, blocked, posClosed, good, closeCmd, openCmd};

  // bounded wait on a settled output level
  task automatic waitFor(input int which, input logic lvl);
    int n;
    n = 0;
    while (watch[which] !== lvl && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(16'(watch[which]), 16'(lvl));
  endtask

  // straps move only under reset, so each case resets
  task automatic cfg(input logic [3:0] s, input logic [4:0] pk, input logic [2:0] mc, input logic sk,
                     input logic ck, input logic [49:0] act, input logic [1:0] expH, input logic [1:0] expE);
    @(posedge clk);
    rstN <= 1'b0;
    straps <= s;
    connPick <= pk;
    maxCyc <= mc;
    skipEn <= sk;
    readyChk <= ck;
    action <= act;
    repeat (8) @(posedge clk);
    rstN <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(16'(health), 16'(expH));
    if (expH != ALM) chk(16'({skipAct, readyAct}), 16'(expE));
  endtask

  task automatic ldCnt(input logic [2:0] sel, input logic [15:0] val);
    @(posedge clk);
    ldEn <= 1'b1;
    ldSel <= sel;
    ldVal <= val;
    @(posedge clk);
    ldEn <= 1'b0;
  endtask

  task automatic rdCnt(input logic [2:0] sel, input logic [15:0] exp);
    @(posedge clk);
    rdSel <= sel;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(rdData, exp);
  endtask

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    // health for each strap or setting fault, plus one case of alarm with warnings
    cfg(4'h7, 5'h1f, 3'h1, 1'b0, 1'b1, 50'h2, ALM, 2'h0);
    cfg(4'h5, 5'h1f, 3'h2, 1'b1, 1'b1, 50'h32, ALM, 2'h0);
    cfg(4'hf, 5'h1f, 3'h2, 1'b0, 1'b1, 50'h2, WRN, 2'h1);
    cfg(4'hf, 5'h1f, 3'h1, 1'b1, 1'b1, 50'h2, WRN, 2'h1);
    cfg(4'hb, 5'h1f, 3'h2, 1'b1, 1'b1, 50'h2, NRM, 2'h3);
    cfg(4'hf, 5'h1e, 3'h1, 1'b0, 1'b1, 50'h2, WRN, 2'h1);
    cfg(4'he, 5'h1f, 3'h1, 1'b0, 1'b1, 50'h2, WRN, 2'h1);
    cfg(4'hf, 5'h1f, 3'h1, 1'b0, 1'b1, 50'he, WRN, 2'h1);
    cfg(4'hf, 5'h1f, 3'h1, 1'b0, 1'b1, 50'h3, NRM, 2'h1);
    cfg(4'hf, 5'h1d, 3'h1, 1'b0, 1'b1, 50'h402, WRN, 2'h1);
    cfg(4'hd, 5'h1f, 3'h1, 1'b0, 1'b1, 50'h2, WRN, 2'h0);
    cfg(4'hd, 5'h1f, 3'h1, 1'b0, 1'b0, 50'h2, NRM, 2'h0);
    cfg(4'hf, 5'h1f, 3'h1, 1'b0, 1'b1, 50'h2, NRM, 2'h1);
    // a live setting change is seen without reset
    @(posedge clk);
    action <= 50'h32;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(16'(health), 16'(WRN));
    $display("test health table done");
    // good sequence, slow breaker, master holding the close back a while
    cfg(4'hf, 5'h1f, 3'h1, 1'b0, 1'b1, 50'h2, NRM, 2'h1);
    ldCnt(3'h0, 16'h0041);
    @(posedge clk);
    strokeDly <= 4'h5;
    pickPins <= 30'h20;
    tripPin <= 1'b1;
    holdPin <= 1'b1;
    waitFor(0, 1'b1);
    chk(16'(flags), 16'h0001);
    waitFor(3, 1'b0);
    @(posedge clk);
    pickPins <= 30'h0;
    tripPin <= 1'b0;
    deadDone <= 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk(16'(closeCmd), 16'h0);
    @(posedge clk);
    holdPin <= 1'b0;
    waitFor(1, 1'b1);
    waitFor(3, 1'b1);
    @(posedge clk);
    deadDone <= 1'b0;
    reclaimDone <= 1'b1;
    waitFor(2, 1'b1);
    chk(16'(flags), 16'h0);
    @(posedge clk);
    reclaimDone <= 1'b0;
    rdCnt(3'h0, 16'h0042);
    rdCnt(3'h2, 16'h0001);
    $display("test sequence done");
    // block pin: shown on status and a fault is left alone
    @(posedge clk);
    blockPin <= 1'b1;
    waitFor(4, 1'b1);
    @(posedge clk);
    pickPins <= 30'h1;
    tripPin <= 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(16'({openCmd, flags}), 16'h0);
    @(posedge clk);
    pickPins <= 30'h0;
    tripPin <= 1'b0;
    blockPin <= 1'b0;
    waitFor(4, 1'b0);
    $display("test block done");
    // every counter word loads and reads back; unused select reads zero
    for (int i = 0; i < 7; i++) begin
      ldCnt(3'(i), 16'h1000 + 16'(i));
      rdCnt(3'(i), 16'h1000 + 16'(i));
    end
    rdCnt(3'h7, 16'h0);
    @(posedge clk);
    pickPins <= 30'h1;
    tripPin <= 1'b1;
    waitFor(0, 1'b1);
    @(posedge clk);
    blockPin <= 1'b1;
    waitFor(5, 1'b1);
    rdCnt(3'h1, 16'h1002);
    $display("test counters done");
    // alarm: a real fault gets no breaker action
    cfg(4'h7, 5'h1f, 3'h1, 1'b0, 1'b1, 50'h2, ALM, 2'h0);
    @(posedge clk);
    blockPin <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(16'({openCmd, flags}), 16'h0);
    $display("test alarm done");
    endOfTest();
  end
endmodule // rbh_core_bench
